// File: design/bpw_top.v
// Purpose: Setup and base address logic of an even/odd window pair.
// Assumes: AXI4-Lite master keeps one write and one read outstanding.
// Notes:   Window hits are registered one cycle after a probe.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bpw_map.vh"

// Contract
// [R1] Width code 0 is 32-bit, 2 is 64-bit, 1 and 3 reserved.
// [R2] Window type field echoes width; width steers decoding only in memory.
// [R3] Window space bit echoes memory/IO select: 0 memory, 1 I/O.
// [R4] Odd window with enable and size zero is off and reads zero.
// [R5] Even 64-bit memory makes odd window the upper base half.
// [R6] A valid size requests two to the size bytes.
// [R7] Base field bit 0 is address bit 4.
// [R8] Base bits at or above the size are writable.
// [R9] Size below four makes every base bit read-only zero.
// [R10] Software picks size seven or more, at most 2^31 bytes.
// [R11] Odd window size above 31 is limited to 32-bit addressing.
// [R12] Window prefetch bit echoes the prefetch select.
// [R13] Reserved setup bits read zero and ignore writes.
module bpw_top (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire probe_valid,
	input wire [63:0] probe_addr,
	input wire probe_io,
	output wire lower_hit,
	output wire upper_hit,
	output wire pair_64
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	reg [31:0] lsetup_q;
	reg [31:0] usetup_q;
	reg [31:0] lbar_q;
	reg [31:0] ubar_q;
	reg aw_held_q;
	reg [11:0] awaddr_q;
	reg w_held_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	reg lhit_q;
	reg uhit_q;

	// ----------------------------------------------------------------
	// Setup fields
	// ----------------------------------------------------------------
	wire l_en = lsetup_q[`BPW_EN_BIT];
	wire [5:0] l_size = lsetup_q[`BPW_SIZE_HI:`BPW_SIZE_LO];
	wire l_prefetch_select = lsetup_q[`BPW_PREFETCH_SELECT_BIT];
	wire [1:0] l_type = lsetup_q[`BPW_TYPE_HI:`BPW_TYPE_LO];
	wire l_memory_io_select = lsetup_q[`BPW_MEMORY_IO_SELECT_BIT];
	wire u_en = usetup_q[`BPW_EN_BIT];
	wire [5:0] u_size_raw = usetup_q[`BPW_SIZE_HI:`BPW_SIZE_LO];
	wire u_prefetch_select = usetup_q[`BPW_PREFETCH_SELECT_BIT];
	wire [1:0] u_type = usetup_q[`BPW_TYPE_HI:`BPW_TYPE_LO];
	wire u_memory_io_select = usetup_q[`BPW_MEMORY_IO_SELECT_BIT];

	// Reserved width codes 1 and 3 decode as 32-bit.
	wire l_is64 = (l_type == `BPW_TYPE_64); // R1
	wire l_mem = (l_memory_io_select == `BPW_SPACE_MEM); // R3
	wire pair64 = l_mem && l_is64; // R5
	wire l_off = !l_en && (l_size == 6'h00);
	wire u_off = !u_en && (u_size_raw == 6'h00); // R4
	wire [5:0] u_size = (u_size_raw > `BPW_SIZE_ODD_MAX) ?
		`BPW_SIZE_ODD_MAX : u_size_raw; // R11

	// ----------------------------------------------------------------
	// Writable masks
	// ----------------------------------------------------------------
	wire [31:0] lmask_raw;
	wire [31:0] hmask;
	wire [31:0] umask_raw;

	bpw_win u_lmask (
		.size(l_size),
		.lsb(`BPW_LOWER_LSB),
		.mask(lmask_raw)
	);

	bpw_win u_hmask (
		.size(l_size),
		.lsb(`BPW_UPPER_LSB),
		.mask(hmask)
	);

	bpw_win u_umask (
		.size(u_size),
		.lsb(`BPW_LOWER_LSB),
		.mask(umask_raw)
	);

	// Low nibble of a base word holds the flag fields, address bit 4 up.
	wire [31:0] lmask = lmask_raw & `BPW_BASE_FIELD_MASK; // R7
	wire [31:0] umask_own = umask_raw & `BPW_BASE_FIELD_MASK; // R7
	wire [31:0] umask = pair64 ? hmask : umask_own; // R5

	// ----------------------------------------------------------------
	// Window read values
	// ----------------------------------------------------------------
	// Base bits are masked as they are written. A later larger size only
	// hides stored bits on read, so a smaller size shows them again.
	wire [31:0] lbar_rd;
	wire [31:0] ubar_rd;

	assign lbar_rd = l_off ? 32'h0000_0000 :
		((lbar_q & lmask) | {28'h000_0000, l_prefetch_select, l_type, l_memory_io_select});
	// R2 R3 R12 R6

	// In pair mode the odd setup word is kept but has no effect.
	assign ubar_rd = pair64 ? (l_off ? 32'h0000_0000 : (ubar_q & hmask)) :
		(u_off ? 32'h0000_0000 : // R4
		((ubar_q & umask_own) | {28'h000_0000, u_prefetch_select, u_type, u_memory_io_select}));
	// R5 R2 R3 R12

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_go = aw_held_q && w_held_q && !bvalid_q;

	wire [31:0] wbyte = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	// Byte lanes within a word are chosen by the strobes, not the address.
	wire [11:0] wr_word = {awaddr_q[11:2], 2'b00};
	wire wr_lsetup = (wr_word == `BPW_OFS_LOWER_SETUP);
	wire wr_usetup = (wr_word == `BPW_OFS_UPPER_SETUP);
	wire wr_lbar = (wr_word == `BPW_OFS_LOWER_BAR);
	wire wr_ubar = (wr_word == `BPW_OFS_UPPER_BAR);
	wire wr_hit = wr_lsetup || wr_usetup || wr_lbar || wr_ubar;

	wire [31:0] setup_we = wbyte & `BPW_SETUP_RW_MASK; // R13
	wire [31:0] lbar_we = wbyte & lmask; // R8
	wire [31:0] ubar_we = wbyte & umask; // R8

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q <= 12'h000;
			w_held_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `BPW_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? `BPW_RESP_OKAY : `BPW_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// ----------------------------------------------------------------
	// Register updates
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			lsetup_q <= `BPW_LOWER_RESET;
			usetup_q <= `BPW_UPPER_RESET;
			lbar_q <= 32'h0000_0000;
			ubar_q <= 32'h0000_0000;
		end else if (wr_go) begin
			if (wr_lsetup) begin
				lsetup_q <= (lsetup_q & ~setup_we) | (wdata_q & setup_we);
			end
			// Odd setup stays writable even while paired.
			if (wr_usetup) begin
				usetup_q <= (usetup_q & ~setup_we) | (wdata_q & setup_we);
			end
			if (wr_lbar) begin
				lbar_q <= (lbar_q & ~lbar_we) | (wdata_q & lbar_we); // R8
			end
			if (wr_ubar) begin
				ubar_q <= (ubar_q & ~ubar_we) | (wdata_q & ubar_we); // R8
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = !rvalid_q;

	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [11:0] rd_word = {s_axi_araddr[11:2], 2'b00};
	reg [31:0] rd_mux;
	reg rd_hit;

	always @* begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (rd_word)
			`BPW_OFS_LOWER_SETUP: begin
				rd_mux = lsetup_q & `BPW_SETUP_RW_MASK; // R13
			end
			`BPW_OFS_UPPER_SETUP: begin
				rd_mux = usetup_q & `BPW_SETUP_RW_MASK; // R13
			end
			`BPW_OFS_LOWER_BAR: begin
				rd_mux = lbar_rd;
			end
			`BPW_OFS_UPPER_BAR: begin
				rd_mux = ubar_rd;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `BPW_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_hit ? `BPW_RESP_OKAY : `BPW_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ----------------------------------------------------------------
	// Address decoding
	// ----------------------------------------------------------------
	// Even window: 64-bit compare only for 64-bit memory, else the
	// upper address half must be zero.
	wire [63:0] l_base = {pair64 ? ubar_q : 32'h0000_0000, lbar_q};
	wire [63:0] l_amask = {pair64 ? hmask : 32'h0000_0000, lmask};
	wire l_hi_ok = pair64 || (probe_addr[63:32] == 32'h0000_0000); // R2
	wire l_live = !l_off && (l_size >= `BPW_SIZE_MIN); // R9
	wire l_match = (((probe_addr ^ l_base) & l_amask) == 64'h0) &&
		l_hi_ok && (probe_io == l_memory_io_select);

	// Odd window decodes 32-bit only and is silent while paired.
	wire u_live = !pair64 && !u_off && (u_size >= `BPW_SIZE_MIN);
	// R5 R4 R9
	wire u_match = (((probe_addr[31:0] ^ ubar_q) & umask_own) ==
		32'h0000_0000) && (probe_addr[63:32] == 32'h0000_0000) &&
		(probe_io == u_memory_io_select); // R11

	always @(posedge aclk) begin
		if (!aresetn) begin
			lhit_q <= 1'b0;
			uhit_q <= 1'b0;
		end else begin
			lhit_q <= probe_valid && l_live && l_match; // R6
			uhit_q <= probe_valid && u_live && u_match; // R6
		end
	end

	assign lower_hit = lhit_q;
	assign upper_hit = uhit_q;
	assign pair_64 = pair64;

endmodule // bpw_top
`default_nettype wire

// File: pkg/bpw_map.vh
// Purpose: Offsets, field positions and reset values of the window pair.
// Assumes: Included by every design file of the window pair block.
// Notes:   Definitions only.
`ifndef BPW_MAP_VH
`define BPW_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define BPW_ADDR_W          12
`define BPW_OFS_LOWER_BAR   12'h010
`define BPW_OFS_UPPER_BAR   12'h014
`define BPW_OFS_LOWER_SETUP 12'h450
`define BPW_OFS_UPPER_SETUP 12'h454

// ----------------------------------------------------------------------
// Setup register fields
// ----------------------------------------------------------------------
`define BPW_EN_BIT          31
`define BPW_SIZE_HI         9
`define BPW_SIZE_LO         4
`define BPW_PREFETCH_SELECT_BIT        3
`define BPW_TYPE_HI         2
`define BPW_TYPE_LO         1
`define BPW_MEMORY_IO_SELECT_BIT       0
`define BPW_SETUP_RW_MASK   32'h8000_03FF
`define BPW_LOWER_RESET     32'h8000_0184
`define BPW_UPPER_RESET     32'h0000_0000

// ----------------------------------------------------------------------
// Field encodings and limits
// ----------------------------------------------------------------------
`define BPW_TYPE_32         2'h0
`define BPW_TYPE_64         2'h2
`define BPW_SPACE_MEM       1'h0
`define BPW_SPACE_IO        1'h1
`define BPW_SIZE_MIN        6'h04
`define BPW_SIZE_ODD_MAX    6'h1F
`define BPW_UPPER_LSB       6'h20
`define BPW_LOWER_LSB       6'h00
`define BPW_BASE_FIELD_MASK 32'hFFFF_FFF0

// ----------------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------------
`define BPW_RESP_OKAY       2'h0
`define BPW_RESP_SLVERR     2'h2

`endif

// File: design/bpw_win.v
// Purpose: Writable-bit mask of one 32-bit base address word.
// Assumes: Bit 0 of the word maps to address bit lsb.
// Notes:   A size below the minimum clears the whole mask.
`timescale 1ns/1ps
`default_nettype none
`include "bpw_map.vh"

module bpw_win (
	input wire [5:0] size,
	input wire [5:0] lsb,
	output wire [31:0] mask
);

	// ----------------------------------------------------------------
	// Per-bit mask
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1) begin : g_bit
			localparam [6:0] OFS = i;
			wire [6:0] pos = {1'b0, lsb} + OFS;
			assign mask[i] = (size >= `BPW_SIZE_MIN) && // R9
				(pos >= {1'b0, size}); // R8
		end
	endgenerate

endmodule // bpw_win
`default_nettype wire

// File: verification/bpw_top_assertions.sv
// Purpose: Timing checks on the ports of bpw_top.
// Assumes: One clock; reset is synchronous and active low.
// Notes:   Bound to every bpw_top instance.
`timescale 1ns/1ps
`default_nettype none
module bpw_top_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic probe_valid,
	input wire logic lower_hit,
	input wire logic upper_hit,
	input wire logic pair_64
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence aw_w_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence ar_s;
		s_axi_arvalid && s_axi_arready;
	endsequence
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("write response dropped");
	b_after_a: assert property (aw_w_s |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	unmapped_read_a: assert property (ar_s and s_axi_araddr[11:3] != 9'h08A
		&& s_axi_araddr[11:3] != 9'h002 |=> s_axi_rresp == 2'h2
		&& s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
	setup_zero_a: assert property (ar_s and s_axi_araddr[11:3] == 9'h08A
		|=> s_axi_rdata[30:10] == 21'h00_0000) else $error("reserved set");
	upper_pair_a: assert property (upper_hit |-> !$past(pair_64))
		else $error("odd hit in pair mode");
	hit_cause_a: assert property (lower_hit || upper_hit
		|-> $past(probe_valid)) else $error("hit without probe");
	pair_change_a: assert property ($changed(pair_64)
		|-> $rose(s_axi_bvalid)) else $error("pair mode without write");
endmodule // bpw_top_chk
bind bpw_top bpw_top_chk i_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.probe_valid, .lower_hit, .upper_hit, .pair_64);
`default_nettype wire

// File: verification/bar_pair_window_setup_tb.sv
// Purpose: Self-checking bench for the window pair setup block.
// Assumes: One write and one read outstanding at most.
// Notes:   Each row writes one word, then reads one word, the same word or another.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED at %0t: got %h want %h", $time, g, e); end end
module bar_pair_window_setup_tb;
	typedef struct packed {logic [11:0] wa; logic [31:0] wd;
		logic [11:0] ra; logic [31:0] re;} bpw_row_t;
	logic aclk = 0;
	logic aresetn = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic probe_valid = 0, probe_io = 0, slow = 0;
	logic [63:0] probe_addr = 0;
	wire awready, wready, bvalid, arready, rvalid, lower_hit, upper_hit;
	wire pair_64;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int fail_count = 0, checks = 0;
	bpw_row_t rows [12] = '{
		'{12'h454, 32'hFFFF_FFFF, 12'h454, 32'h8000_03FF},
		'{12'h450, 32'h8000_0108, 12'h450, 32'h8000_0108},
		'{12'h010, 32'hFFFF_FFFF, 12'h010, 32'hFFFF_0008},
		'{12'h014, 32'hFFFF_FFFF, 12'h014, 32'h8000_000F},
		'{12'h454, 32'h0000_0000, 12'h014, 32'h0000_0000},
		'{12'h454, 32'h8000_0030, 12'h014, 32'h0000_0000},
		'{12'h014, 32'hFFFF_FFFF, 12'h014, 32'h0000_0000},
		'{12'h454, 32'h8000_0070, 12'h014, 32'h8000_0000},
		'{12'h014, 32'hFFFF_FFFF, 12'h014, 32'hFFFF_FF80},
		'{12'h450, 32'h8000_0184, 12'h014, 32'hFFFF_FF80},
		'{12'h014, 32'hFFFF_FFFF, 12'h014, 32'hFFFF_FFFF},
		'{12'h010, 32'h1234_5678, 12'h010, 32'h1200_0004}};
	bpw_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.probe_valid(probe_valid), .probe_addr(probe_addr),
		.probe_io(probe_io), .lower_hit(lower_hit), .upper_hit(upper_hit),
		.pair_64(pair_64));
	always #2.5 aclk = ~aclk;
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !slow;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (slow && n == 3) bready <= 1'b1;
		end while (!(bvalid && bready));
		bready <= 1'b0;
		`CHK(bresp, er)
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !slow;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (slow && n == 3) rready <= 1'b1;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		`CHK(rdata, e)
		`CHK(rresp, er)
		@(posedge aclk);
	endtask
	task automatic pr(input logic [63:0] a, input logic io,
		input logic [1:0] e);
		probe_addr <= a;
		probe_io <= io;
		probe_valid <= 1'b1;
		@(posedge aclk);
		probe_valid <= 1'b0;
		#1;
		`CHK({lower_hit, upper_hit}, e)
		@(posedge aclk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#50000;
		fail_count++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(12'h450, 32'h8000_0184, 2'h0);
		rd(12'h454, 32'h0000_0000, 2'h0);
		rd(12'h010, 32'h0000_0004, 2'h0);
		`CHK(pair_64, 1'b1)
		$display("reset values done");
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd, 2'h0);
			rd(rows[i].ra, rows[i].re, 2'h0);
		end
		$display("table rows done");
		wr(12'h100, 32'hFFFF_FFFF, 2'h2);
		rd(12'h100, 32'h0000_0000, 2'h2);
		pr(64'hFFFF_FFFF_12AB_CDEF, 1'b0, 2'b10);
		pr(64'hFFFF_FFFF_12AB_CDEF, 1'b1, 2'b00);
		pr(64'hFFFF_FFFF_1300_0000, 1'b0, 2'b00);
		pr(64'h0000_0000_FFFF_FFA0, 1'b0, 2'b00);
		wr(12'h450, 32'h8000_0103, 2'h0);
		`CHK(pair_64, 1'b0)
		pr(64'h0000_0000_12FF_5678, 1'b1, 2'b10);
		pr(64'h0000_0000_12FF_5678, 1'b0, 2'b00);
		pr(64'h0000_0000_FFFF_FFA0, 1'b0, 2'b01);
		pr(64'h0000_0000_FFFF_FF7F, 1'b0, 2'b00);
		pr(64'h0000_0001_FFFF_FFA0, 1'b0, 2'b00);
		$display("probe tests done");
		// Late ready: the responses must stand until they are taken.
		slow = 1'b1;
		wr(12'h454, 32'h8000_0070, 2'h0);
		rd(12'h454, 32'h8000_0070, 2'h0);
		slow = 1'b0;
		$display("slow ready done");
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(12'h450, 32'h8000_0184, 2'h0);
		`CHK(pair_64, 1'b1)
		$display("second reset done");
		print_verdict();
	end
endmodule // bar_pair_window_setup_tb
`default_nettype wire
